/* File: design/flash_status_and_protection.sv */
// command decode, status registers, write protection and completion pin
`timescale 1ns/1ps
module flash_status_and_protection
    import flash_status_pkg::*;
#(
    parameter int NUM_BLOCKS = 32,  // number of erase blocks
    parameter int BLOCK_W    = 5    // block address width
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // device pins
    input  wire logic               reset_powerdown_n,
    input  wire logic               wp,
    input  wire logic               vpp_ok,
    // parallel command bus
    input  wire logic               bus_wr,
    input  wire logic               bus_rd,
    input  wire logic [7:0]         bus_data_in,
    input  wire logic [BLOCK_W-1:0] bus_block,
    output logic      [7:0]         bus_data_out,
    // completion pin, open drain low
    output logic                    pin_out,
    output logic                    pin_oe
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (NUM_BLOCKS < 2 || NUM_BLOCKS > (1 << BLOCK_W)) begin : g_bad_blocks
        $error("NUM_BLOCKS does not fit BLOCK_W");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // operation refused by lock-bit and write-protect
    function automatic logic blocked(op_kind_t k, logic lk, logic wpin);
        unique case (k)
            OP_ERASE, OP_WRITE:     blocked = lk && !wpin;
            OP_SETLOCK, OP_CLRLOCK: blocked = !wpin;
            default:                blocked = 1'b0;         // chip erase is never blocked
        endcase
    endfunction : blocked

    // erase-class operations report in bit 5, the rest in bit 4
    function automatic logic erase_class(op_kind_t k);
        erase_class = (k == OP_ERASE) || (k == OP_CHIP) || (k == OP_CLRLOCK);
    endfunction : erase_class

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cmd_state_t             state, next_state;        // command sequence position
    read_mode_t             rmode, next_rmode;        // what a read returns
    logic [1:0]             mode, next_mode;          // completion pin mode
    logic                   busy, next_busy;          // write_state_machine busy
    logic [6:0]             cnt, next_cnt;            // operation length counter
    op_kind_t               op, next_op;              // running operation
    logic [BLOCK_W-1:0]     op_block, next_op_block;  // target block
    logic                   op_blocked, next_op_blocked;
    logic [NUM_BLOCKS-1:0]  lock, next_lock;          // block lock-bits
    logic                   efail, next_efail;        // sticky error flags
    logic                   pfail, next_pfail;
    logic                   vlow, next_vlow;
    logic                   pfault, next_pfault;
    logic [3:0]             pulse, next_pulse;        // pulse countdown
    logic                   next_pin_oe;
    logic [7:0]             next_bus_data_out;
    logic [7:0]             status_reg;               // operation_status_reg view
    logic [7:0]             xstatus_reg;              // write_buffer_status_reg view
    logic                   done;                     // last busy cycle
    logic                   cmd_ok;                   // command write accepted

    // suspend is not modelled, so bits 6 and 2 stay clear; bit 0 reserved
    assign status_reg  = {!busy, 1'b0, efail, pfail, vlow, 1'b0, pfault, 1'b0};
    assign xstatus_reg = {!busy, 7'h00};
    assign done        = busy && (cnt == 7'd1);
    // while busy only status reads get through; powerdown blocks everything
    assign cmd_ok      = bus_wr && reset_powerdown_n && !busy;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_state        = state;
        next_rmode        = rmode;
        next_mode         = mode;
        next_busy         = busy;
        next_cnt          = cnt;
        next_op           = op;
        next_op_block     = op_block;
        next_op_blocked   = op_blocked;
        next_lock         = lock;
        next_efail        = efail;
        next_pfail        = pfail;
        next_vlow         = vlow;
        next_pfault       = pfault;
        next_pulse        = (pulse != 4'h0) ? pulse - 4'h1 : 4'h0;
        // clear first, so a fault found this cycle still lands
        if (cmd_ok && state == S_IDLE && bus_data_in == CMD_CLEAR_STATUS) begin
            next_efail  = 1'b0;
            next_pfail  = 1'b0;
            next_vlow   = 1'b0;
            next_pfault = 1'b0;
        end
        // operation countdown and result
        if (busy) begin
            next_cnt = cnt - 7'd1;
            if (done) begin
                next_busy = 1'b0;
                if (op_blocked) begin
                    next_pfault = 1'b1;
                    if (erase_class(op)) next_efail = 1'b1;
                    else next_pfail = 1'b1;
                end else if (!vpp_ok) begin
                    next_vlow = 1'b1;
                    if (erase_class(op)) next_efail = 1'b1;
                    else next_pfail = 1'b1;
                end else if (op == OP_SETLOCK) begin
                    next_lock[op_block] = 1'b1;
                end else if (op == OP_CLRLOCK) begin
                    next_lock = '0;
                end
                // pulse only in a matching pulse mode
                if ((mode == CFG_BOTH) ||
                    (mode == CFG_ERASE && erase_class(op)) ||
                    (mode == CFG_WRITE && !erase_class(op))) begin
                    next_pulse = 4'(PULSE_CYC);
                end
            end
        end
        // while busy only a status-read request is honoured
        if (busy && bus_wr && reset_powerdown_n && bus_data_in == CMD_READ_STATUS) begin
            next_rmode = RD_STATUS;
        end
        // command decode
        if (cmd_ok) begin
            next_state = S_IDLE;
            unique case (state)
                S_IDLE: begin
                    unique case (bus_data_in)
                        CMD_ERASE_SETUP:               next_state = S_ERASE;
                        CMD_CHIP_SETUP:                next_state = S_CHIP;
                        CMD_WRITE_SETUP, CMD_WRITE_ALT: next_state = S_WRITE;
                        CMD_LOCK_SETUP:                next_state = S_LOCK;
                        CMD_PIN_CONFIG:                next_state = S_CFG;
                        CMD_READ_STATUS:               next_rmode = RD_STATUS;
                        CMD_READ_ARRAY:                next_rmode = RD_ARRAY;
                        CMD_MULTI_WRITE:               next_rmode = RD_XSTAT;
                        default:                       next_rmode = rmode;
                    endcase
                    if (bus_data_in != CMD_READ_ARRAY && bus_data_in != CMD_MULTI_WRITE)
                        next_rmode = (bus_data_in == CMD_CLEAR_STATUS) ? rmode : RD_STATUS;
                end
                S_ERASE, S_CHIP, S_WRITE, S_LOCK: begin
                    next_rmode = RD_STATUS;
                    if (state == S_WRITE) next_op = OP_WRITE;
                    else if (state == S_ERASE) next_op = OP_ERASE;
                    else if (state == S_CHIP) next_op = OP_CHIP;
                    else next_op = (bus_data_in == CMD_SET_LOCK) ? OP_SETLOCK : OP_CLRLOCK;
                    if (state != S_WRITE && bus_data_in != CMD_CONFIRM &&
                        !(state == S_LOCK && bus_data_in == CMD_SET_LOCK)) begin
                        next_efail = 1'b1;
                        next_pfail = 1'b1;
                        next_op    = op;
                    end else begin
                        next_busy       = 1'b1;
                        next_cnt        = 7'(OP_CYCLES);
                        next_op_block   = bus_block;
                        next_op_blocked = blocked(next_op, lock[bus_block], wp);
                    end
                end
                S_CFG: begin
                    next_rmode = RD_STATUS;
                    if (bus_data_in[7:2] == 6'h00) begin
                        next_mode = bus_data_in[1:0];
                    end else begin
                        next_efail = 1'b1;
                        next_pfail = 1'b1;
                    end
                end
            endcase
        end
        // powerdown aborts and restores the level mode
        if (!reset_powerdown_n) begin
            next_state = S_IDLE;
            next_rmode = RD_ARRAY;
            next_mode  = PIN_MODE_RESET;
            next_busy  = 1'b0;
            next_pulse = 4'h0;
        end
        // level follows busy, pulse modes drive only while pulsing
        next_pin_oe = (next_mode == CFG_LEVEL) ? next_busy : (next_pulse != 4'h0);
        unique case (rmode)
            RD_STATUS: next_bus_data_out = status_reg;
            RD_XSTAT:  next_bus_data_out = xstatus_reg;
            default:   next_bus_data_out = ARRAY_READ_DATA;
        endcase
        if (!bus_rd) next_bus_data_out = bus_data_out;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state        <= S_IDLE;
            rmode        <= RD_ARRAY;
            mode         <= PIN_MODE_RESET;
            busy         <= 1'b0;
            cnt          <= 7'h00;
            op           <= OP_ERASE;
            op_block     <= '0;
            op_blocked   <= 1'b0;
            lock         <= '0;
            efail        <= 1'b0;
            pfail        <= 1'b0;
            vlow         <= 1'b0;
            pfault       <= 1'b0;
            pulse        <= 4'h0;
            pin_oe       <= 1'b0;
            bus_data_out <= 8'h00;
        end else begin
            state        <= next_state;
            rmode        <= next_rmode;
            mode         <= next_mode;
            busy         <= next_busy;
            cnt          <= next_cnt;
            op           <= next_op;
            op_block     <= next_op_block;
            op_blocked   <= next_op_blocked;
            lock         <= next_lock;
            efail        <= next_efail;
            pfail        <= next_pfail;
            vlow         <= next_vlow;
            pfault       <= next_pfault;
            pulse        <= next_pulse;
            pin_oe       <= next_pin_oe;
            bus_data_out <= next_bus_data_out;
        end
    end

    // open drain: the pin is only ever pulled low
    always_ff @(posedge clk) begin
        pin_out <= 1'b0;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence pulse_start_s;
        $rose(pin_oe) && mode != CFG_LEVEL;
    endsequence
    sequence pulse_body_s;
        pin_oe [*5] ##1 !pin_oe;
    endsequence

    AST_MODE_HOLD: assert property ($changed(mode) |-> !$past(reset_powerdown_n) ||
        ($past(cmd_ok) && $past(state) == S_CFG)) else $error("pin mode changed without cause");
    AST_PD_DEFAULT: assert property (!reset_powerdown_n |=> mode == CFG_LEVEL && !pin_oe)
        else $error("powerdown did not restore level mode");
    AST_LEVEL_PIN: assert property (mode == CFG_LEVEL && $past(mode) == CFG_LEVEL
        |-> pin_oe == busy) else $error("level pin does not follow busy");
    AST_PULSE_WIDTH: assert property (pulse_start_s |-> pulse_body_s)
        else $error("completion pulse width wrong");
    AST_PROTECT: assert property (done && op_blocked |=> pfault && lock == $past(lock))
        else $error("blocked operation not reported");
    AST_VPP: assert property (done && !op_blocked && !vpp_ok |=> vlow)
        else $error("supply low not reported");
    AST_IMPROPER: assert property (cmd_ok && state == S_ERASE && bus_data_in != CMD_CONFIRM
        |=> efail && pfail && !busy) else $error("improper sequence not flagged");
    AST_STICKY: assert property (efail && !(cmd_ok && state == S_IDLE &&
        bus_data_in == CMD_CLEAR_STATUS) |=> efail) else $error("error flag lost");
    AST_READY_BIT: assert property (bus_rd && rmode == RD_STATUS
        |=> bus_data_out[SR_READY_BIT] == !$past(busy)) else $error("ready bit wrong");
    AST_LOCK_WP: assert property (cmd_ok && state == S_LOCK && !wp
        |=> ##64 lock == $past(lock, 65)) else $error("lock changed without protect high");

endmodule : flash_status_and_protection

/* File: inc/flash_status_pkg.sv */
// constants and types for the flash status and protection block
package flash_status_pkg;

    // ------------------------------------------------------------
    // command codes seen on the data bus
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;  // block erase setup
    localparam logic [7:0] CMD_CHIP_SETUP   = 8'h30;  // full chip erase setup
    localparam logic [7:0] CMD_WRITE_SETUP  = 8'h40;  // word/byte write setup
    localparam logic [7:0] CMD_WRITE_ALT    = 8'h10;  // alternate write setup
    localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;  // lock-bit setup
    localparam logic [7:0] CMD_SET_LOCK     = 8'h01;  // set lock-bit confirm
    localparam logic [7:0] CMD_CONFIRM      = 8'hd0;  // erase / clear-locks confirm
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;  // enter status-read mode
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;  // clear error flags
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;  // back to array read
    localparam logic [7:0] CMD_MULTI_WRITE  = 8'he8;  // multi write, extended status
    localparam logic [7:0] CMD_PIN_CONFIG   = 8'hb8;  // completion pin configuration
    localparam logic [7:0] ARRAY_READ_DATA  = 8'hff;  // array contents are not modelled

    // ------------------------------------------------------------
    // completion pin configuration codes
    // ------------------------------------------------------------
    localparam logic [1:0] CFG_LEVEL = 2'h0;  // ready_busy_level
    localparam logic [1:0] CFG_ERASE = 2'h1;  // pulse on erase-class end
    localparam logic [1:0] CFG_WRITE = 2'h2;  // pulse on write-class end
    localparam logic [1:0] CFG_BOTH  = 2'h3;  // pulse on either

    // ------------------------------------------------------------
    // status register bit positions and pin mode reset value
    // ------------------------------------------------------------
    localparam int         SR_READY_BIT    = 7;  // machine_ready_flag
    localparam int         SR_ESUSP_BIT    = 6;  // erase_suspend_flag
    localparam int         SR_EFAIL_BIT    = 5;  // erase_fail_flag
    localparam int         SR_PFAIL_BIT    = 4;  // program_fail_flag
    localparam int         SR_VLOW_BIT     = 3;  // supply_low_flag
    localparam int         SR_PSUSP_BIT    = 2;  // program_suspend_flag
    localparam int         SR_PROT_BIT     = 1;  // protect_fault_flag
    localparam int         XSR_AVAIL_BIT   = 7;  // buffer_avail_flag
    localparam logic [1:0] PIN_MODE_RESET  = CFG_LEVEL;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 50;   // system clock rate
    localparam int PULSE_NS     = 100;  // completion pulse width
    localparam int PULSE_CYC    = (PULSE_NS * CLK_MHZ + 999) / 1000;  // rounded up
    localparam int OP_CYCLES    = 64;   // modelled operation length

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_ERASE = 6'b000010,
        S_CHIP  = 6'b000100,
        S_WRITE = 6'b001000,
        S_LOCK  = 6'b010000,
        S_CFG   = 6'b100000
    } cmd_state_t;

    typedef enum logic [4:0] {
        OP_ERASE   = 5'b00001,
        OP_CHIP    = 5'b00010,
        OP_WRITE   = 5'b00100,
        OP_SETLOCK = 5'b01000,
        OP_CLRLOCK = 5'b10000
    } op_kind_t;

    typedef enum logic [2:0] {
        RD_ARRAY  = 3'b001,
        RD_STATUS = 3'b010,
        RD_XSTAT  = 3'b100
    } read_mode_t;

endpackage : flash_status_pkg

/* File: test/flash_host.sv */
// host-side bus model: command writes and status reads on the parallel bus
`timescale 1ns/1ps
module flash_host (
    // clock
    input  wire logic       clk,
    // parallel command bus
    output logic            bus_wr,
    output logic            bus_rd,
    output logic [7:0]      bus_data_in,
    output logic [4:0]      bus_block,
    input  wire logic [7:0] bus_data_out
);
    // idle bus at time zero
    initial begin
        bus_wr      = 1'b0;
        bus_rd      = 1'b0;
        bus_data_in = 8'h00;
        bus_block   = 5'h00;
    end

    // one write strobe; released lines show the inverse, never a stale value
    task automatic wr(input logic [7:0] d, input logic [4:0] b);
        @(negedge clk);
        bus_wr      <= 1'b1;
        bus_data_in <= d;
        bus_block   <= b;
        @(negedge clk);
        bus_wr      <= 1'b0;
        bus_data_in <= ~d;
        bus_block   <= ~b;
    endtask : wr

    // one read strobe, answer taken once registered
    task automatic rd(output logic [7:0] q);
        @(negedge clk);
        bus_rd <= 1'b1;
        @(negedge clk);
        bus_rd <= 1'b0;
        @(negedge clk);
        q = bus_data_out & 8'hfe;
    endtask : rd
endmodule : flash_host

/* File: test/tb_top.sv */
// self-checking bench for the flash status and protection block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb_top
    import flash_status_pkg::*;
;
    // ------------------------------------------------------------
    // signals and reference state
    // ------------------------------------------------------------
    logic       clk = 1'b0, resetn = 1'b0, rpd_n = 1'b1, wp = 1'b0, vpp_ok = 1'b1;
    logic       bus_wr, bus_rd, pin_out, pin_oe, pin_level;
    logic [7:0] bus_data_in, bus_data_out, st;
    logic [4:0] bus_block;
    logic [7:0] flags = 8'h00;          // sticky error bits expected
    int         n_fail = 0, n_compared = 0, n_low = 0, mode = 0;
    bit         lock [32];              // expected lock-bits

    always #10 clk = ~clk;
    // open-drain pin with pull-up
    assign pin_level = pin_oe ? pin_out : 1'b1;
    // low-cycle counter for pin checks
    always @(posedge clk) if (pin_level === 1'b0) n_low++;

    flash_status_and_protection #(.NUM_BLOCKS(32), .BLOCK_W(5)) flash_status_and_protection_i (
        .clk(clk), .resetn(resetn), .reset_powerdown_n(rpd_n), .wp(wp), .vpp_ok(vpp_ok),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_data_in(bus_data_in), .bus_block(bus_block),
        .bus_data_out(bus_data_out), .pin_out(pin_out), .pin_oe(pin_oe));
    flash_host flash_host_i (.clk(clk), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_data_in(bus_data_in), .bus_block(bus_block), .bus_data_out(bus_data_out));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic status(input logic [7:0] mask);
        flash_host_i.wr(CMD_READ_STATUS, 5'h00);
        flash_host_i.rd(st);
        `CHK(st & mask, (8'h80 | flags) & mask)
    endtask : status

    // k: 0 erase, 1 chip, 2 write, 3 set lock, 4 clear locks
    task automatic op(input int k, input int b);
        logic [7:0] setup [5] = '{8'h20, 8'h30, 8'h40, 8'h60, 8'h60};
        logic [7:0] conf  [5] = '{8'hd0, 8'hd0, 8'h00, 8'h01, 8'hd0};
        bit ecls, blk;
        int exp_low;
        conf[2] = 8'($urandom);
        ecls = (k == 0 || k == 1 || k == 4);
        blk = (k == 0 || k == 2) ? (lock[b] && !wp) : (k > 2 && !wp);
        n_low = 0;
        flash_host_i.wr(setup[k], 5'(b));
        flash_host_i.wr(conf[k], 5'(b));
        flash_host_i.wr(CMD_READ_STATUS, 5'h00);
        flash_host_i.rd(st);
        `CHK(st[7], 1'b0)
        repeat (OP_CYCLES + 2 * PULSE_CYC) @(negedge clk);
        if (blk) flags |= 8'h02 | (ecls ? 8'h20 : 8'h10);
        else if (!vpp_ok) flags |= 8'h08 | (ecls ? 8'h20 : 8'h10);
        else if (k == 3) lock[b] = 1'b1;
        else if (k == 4) lock = '{default: 1'b0};
        exp_low = (mode == 0) ? OP_CYCLES : (mode == 3 || (mode == 1) == ecls) ? PULSE_CYC : 0;
        if (!blk && vpp_ok) `CHK(n_low, exp_low)
        status(8'hfe);
    endtask : op

    task automatic cfg(input int c);
        flash_host_i.wr(CMD_PIN_CONFIG, 5'h00);
        flash_host_i.wr(8'(c), 5'h00);
        if (rpd_n && c < 4) mode = c;
        else if (rpd_n) flags |= 8'h30;
    endtask : cfg

    task automatic clear;
        flash_host_i.wr(CMD_CLEAR_STATUS, 5'h00);
        flags = 8'h00;
        status(8'hfe);
    endtask : clear

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // watchdog, far beyond the expected run of some 2000 cycles
    initial begin
        #400_000;
        n_fail++;
        finish_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(82));
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        status(8'hfe);
        flash_host_i.wr(CMD_MULTI_WRITE, 5'h00);
        flash_host_i.rd(st);
        `CHK(st & 8'h80, 8'h80)
        flash_host_i.wr(CMD_READ_ARRAY, 5'h00);
        flash_host_i.rd(st);
        `CHK(st, 8'hfe)
        $display("test reset done");
        // every pin mode against both event classes
        for (int c = 0; c < 4; c++) begin
            cfg(c);
            op(0, $urandom_range(31));
            op(2, $urandom_range(31));
        end
        cfg(5);
        status(8'hfe);
        clear();
        op(0, 3);
        $display("test pin modes done");
        op(3, 7);
        op(4, 0);
        clear();
        wp = 1'b1;
        op(3, 7);
        wp = 1'b0;
        op(0, 7);
        op(2, 7);
        op(1, 0);
        op(0, 8);
        clear();
        wp = 1'b1;
        op(0, 7);
        op(1, 0);
        op(4, 0);
        wp = 1'b0;
        op(0, 7);
        $display("test protection done");
        vpp_ok = 1'b0;
        status(8'hfe);
        op(2, 3);
        vpp_ok = 1'b1;
        clear();
        flash_host_i.wr(CMD_ERASE_SETUP, 5'h02);
        flash_host_i.wr(8'h00, 5'h02);
        flags |= 8'h30;
        status(8'hfe);
        clear();
        $display("test supply and sequence done");
        cfg(1);
        rpd_n = 1'b0;
        cfg(2);
        rpd_n = 1'b1;
        mode = 0;
        op(0, $urandom_range(31));
        $display("test powerdown done");
        finish_test();
    end
endmodule : tb_top
